// File: bench/dac_control_and_monitor_select_tb.sv
`include "dcm_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module dac_control_and_monitor_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dcm_pkg::*;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic die_over_temp, hw_power_down, pd_output_state, ref_level_sel, amp_boost;
    logic internal_ref_en, monitor_en, thermal_guard_en, amps_enabled, thermal_tripped;
    logic monitor_routed, monitor_pin_hiz;
    logic [4:0] toggle_group_en;
    logic [39:0] toggle_use_b, exp_b = '0;
    dcm_fn_t monitor_channel_addr;
    dcm_word_t pats[2] = '{12'h7e3, 12'h85c};
    int n_mismatch = 0, compares = 0, cycles = 0;

    always #2.5 pclk = ~pclk;
    dcm_link_if link();
    dcm_device #(.ref_level_default(1'b1)) dcm_device_i (.pclk, .presetn, .link(link.device),
        .die_over_temp, .hw_power_down, .pd_output_state, .ref_level_sel, .amp_boost,
        .internal_ref_en, .monitor_en, .thermal_guard_en, .toggle_group_en, .amps_enabled,
        .thermal_tripped, .monitor_channel_addr, .monitor_routed, .monitor_pin_hiz, .toggle_use_b);
    dcm_host dcm_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .link(link.host));
    dcm_link_monitor #(.REF_DEFAULT(12'hc00)) dcm_link_monitor_i (.pclk, .presetn,
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .reg_select_hi(link.reg_select_hi), .reg_select_lo(link.reg_select_lo),
        .function_address(link.function_address), .read_not_write(link.read_not_write),
        .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
        .load_outputs(link.load_outputs));

    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the hang guard lives here, so pollers below need no limit of their own
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test;
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    logic [7:0] mon_view;
    assign mon_view = {monitor_channel_addr, monitor_routed, monitor_pin_hiz};

    task automatic cmd(input logic [1:0] rs, input logic rnw,
                       input dcm_fn_t fn, input dcm_word_t d);
        apb(1'b1, `DCM_APB_CMD, {11'h0, rs, rnw, fn, d});
        do apb(1'b0, `DCM_APB_STATUS, 32'h0); while (rd[`DCM_ST_BUSY] !== 1'b0);
    endtask

    task automatic wr_ctrl(input dcm_word_t w);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_CTRL, w);
    endtask

    task automatic ctrl_rb(input dcm_word_t e);
        cmd(`DCM_RS_SFR, 1'b1, `DCM_FN_CTRL, 12'h000);
        `CHK("ready flag", 1'b1, rd[`DCM_ST_RDATA_VALID])
        apb(1'b0, `DCM_APB_RDATA, 32'h0);
        `CHK("readback", e, rd[11:0])
    endtask

    task automatic fields(input dcm_word_t w);
        logic [10:0] seen;
        seen = {pd_output_state, ref_level_sel, amp_boost, internal_ref_en, monitor_en,
                thermal_guard_en, toggle_group_en};
        `CHK("fields", {w[11:6], w[4:0]}, seen)
    endtask

    task automatic load_chk(input logic [4:0] tog);
        wr_ctrl({7'h60, tog});
        apb(1'b1, `DCM_APB_LOAD, 32'h0);
        repeat (2) @(posedge pclk);
        for (int ch = 0; ch < 40; ch++) exp_b[ch] = tog[ch / 8] & ~exp_b[ch];
        `CHK("toggle", exp_b, toggle_use_b)
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        die_over_temp = 1'b0; hw_power_down = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        fields(12'hc00);
        `CHK("monitor reset", 6'h3f, monitor_channel_addr)
        ctrl_rb(12'hc00);
        foreach (pats[i]) begin
            wr_ctrl(pats[i]);
            fields(pats[i]);
            ctrl_rb(pats[i]);
        end
        cmd(2'b01, 1'b0, `DCM_FN_CTRL, 12'h3ff);
        ctrl_rb(12'h85c);
        wr_ctrl(12'hc80);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_MONITOR, {6'd5, 6'h2a});
        `CHK("monitor", {6'd5, 2'b10}, mon_view)
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_MONITOR, {6'h3f, 6'h00});
        `CHK("monitor off", {6'h3f, 2'b01}, mon_view)
        wr_ctrl(12'hc00);
        `CHK("monitor disabled", 2'b00, mon_view[1:0])
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_MONITOR, {6'd9, 6'h00});
        `CHK("refused", {6'h3f, 1'b1}, {monitor_channel_addr, rd[`DCM_ST_REFUSED]})
        apb(1'b1, `DCM_APB_STATUS, 32'h4);
        apb(1'b0, `DCM_APB_STATUS, 32'h0);
        `CHK("refused clear", 1'b0, rd[`DCM_ST_REFUSED])
        // a read flag on a function with no answer must not leave the host waiting
        cmd(`DCM_RS_SFR, 1'b1, `DCM_FN_NOP, 12'h000);
        `CHK("nop read", 2'b00, {rd[`DCM_ST_REFUSED], rd[`DCM_ST_RDATA_VALID]})
        load_chk(5'b10101);
        load_chk(5'b00110);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_SOFT_PD, 12'h000);
        `CHK("soft down", 1'b0, amps_enabled)
        wr_ctrl(12'h000);
        ctrl_rb(12'hc06);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_SOFT_PU, 12'h000);
        `CHK("soft up", 1'b1, amps_enabled)
        hw_power_down <= 1'b1;
        repeat (4) @(posedge pclk);
        wr_ctrl(12'h000);
        ctrl_rb(12'hc06);
        hw_power_down <= 1'b0;
        repeat (2) @(posedge pclk);
        wr_ctrl(12'hc40);
        die_over_temp <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("trip", 2'b10, {thermal_tripped, amps_enabled})
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_SOFT_PU, 12'h000);
        `CHK("hot power up", 2'b10, {thermal_tripped, amps_enabled})
        die_over_temp <= 1'b0;
        repeat (4) @(posedge pclk);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_SOFT_PU, 12'h000);
        `CHK("cool power up", 2'b01, {thermal_tripped, amps_enabled})
        wr_ctrl(12'hfff);
        cmd(`DCM_RS_SFR, 1'b0, `DCM_FN_SOFT_RST, 12'h000);
        fields(12'hc00);
        ctrl_rb(12'hc00);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", {1'b1, 32'h0}, {err, rd})
        stop_test;
    end
endmodule // dac_control_and_monitor_select_tb

// File: bench/dcm_link_monitor.sv
`include "dcm_params.svh"

module dcm_link_monitor #(
    parameter logic [11:0] REF_DEFAULT = 12'hc00
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              cmd_valid,
    input wire logic              cmd_ready,
    input wire logic              reg_select_hi,
    input wire logic              reg_select_lo,
    input wire dcm_pkg::dcm_fn_t  function_address,
    input wire logic              read_not_write,
    input wire dcm_pkg::dcm_word_t cmd_data,
    input wire logic              rsp_valid,
    input wire dcm_pkg::dcm_word_t rsp_data,
    input wire logic              load_outputs
);
    import dcm_pkg::*;
    logic mon_shadow;
    logic clean;
    logic sfr;
    logic ctrl_wr;
    logic ctrl_rd;

    assign sfr     = cmd_valid && !reg_select_hi && !reg_select_lo;
    assign ctrl_wr = sfr && function_address == `DCM_FN_CTRL && !read_not_write;
    assign ctrl_rd = sfr && function_address == `DCM_FN_CTRL && read_not_write;

    // tracks only what crosses the link; ignored writes still set it, so it errs quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mon_shadow <= 1'b0;
        else if (ctrl_wr) mon_shadow <= cmd_data[`DCM_CR_MON_EN];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) clean <= 1'b1;
        else if (sfr && function_address == `DCM_FN_SOFT_RST) clean <= 1'b1;
        else if (ctrl_wr) clean <= 1'b0;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    readback_answer_a: assert property (ctrl_rd |=> rsp_valid)
        else $error("readback not answered next cycle");
    answer_cause_a: assert property (rsp_valid |-> $past(ctrl_rd))
        else $error("answer without a readback command");
    answer_hold_a: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("readback data moved without an answer");
    reset_value_a: assert property (rsp_valid && clean |-> rsp_data == REF_DEFAULT)
        else $error("readback after reset not default");
    ready_high_a: assert property (cmd_ready)
        else $error("command ready dropped");
    cmd_single_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("commands not serialised");
    monitor_order_a: assert property (sfr && function_address == `DCM_FN_MONITOR |-> mon_shadow)
        else $error("monitor command before monitor enable");
    load_pulse_a: assert property (load_outputs |=> !load_outputs)
        else $error("load pulse longer than one cycle");

    cover property (ctrl_rd ##1 rsp_valid);
    cover property (sfr && function_address == `DCM_FN_MONITOR);
    cover property (load_outputs);
endmodule // dcm_link_monitor

// File: hw/dcm_device.sv
// Summary of operation
// - fn 001100: write or readback control register
// - bit 11: power-down output high-z or load
// - bit 10: reference level, default per variant
// - bit 9: amplifier boost, default off
// - bit 8: internal reference enable, default external
// - bit 7: monitor enable, else pin neither routed nor floated
// - host enables monitor, then selects channel
// - monitor address sits in data bits 11:6
// - monitor address 63 floats monitor pin
// - bit 6: thermal shutdown above threshold
// - thermal trip cleared by power-up if cool
// - bits 4:0 enable toggle groups, bit 5 ignored
// - group n covers channels 8n to 8n+7
// - load pulse flips enabled channels A/B
// - special functions decode only with selects 00
// - power-down blocks writes, keeps register contents
`include "dcm_params.svh"

module dcm_device #(
    parameter logic ref_level_default = 1'b1
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    dcm_link_if.device                link,
    input  wire logic                 die_over_temp,
    input  wire logic                 hw_power_down,
    output logic                      pd_output_state,
    output logic                      ref_level_sel,
    output logic                      amp_boost,
    output logic                      internal_ref_en,
    output logic                      monitor_en,
    output logic                      thermal_guard_en,
    output logic [4:0]                toggle_group_en,
    output logic                      amps_enabled,
    output logic                      thermal_tripped,
    output dcm_pkg::dcm_fn_t          monitor_channel_addr,
    output logic                      monitor_routed,
    output logic                      monitor_pin_hiz,
    output logic [`DCM_NUM_CH-1:0]    toggle_use_b
);
    import dcm_pkg::*;

    localparam dcm_word_t cr_reset = `DCM_CR_RESET
                                   | (ref_level_default ? `DCM_CR_REF_MASK : 12'h000);

    dcm_word_t device_control;
    logic      soft_pd;
    logic      ot_meta;
    logic      ot_sync;
    logic      hpd_meta;
    logic      hpd_sync;
    logic      take;
    logic      sfr;
    logic      powered_down;
    logic      do_ctrl_wr;
    logic      do_ctrl_rd;
    logic      do_mon;
    logic      do_pd;
    logic      do_pu;
    logic      do_rst;
    logic      trip_set;

    // always ready: every command except a readback completes in the cycle it is taken
    assign link.cmd_ready = 1'b1;
    assign take = link.cmd_valid & link.cmd_ready;
    assign sfr  = ({link.reg_select_hi, link.reg_select_lo} == `DCM_RS_SFR);

    // pins from the analog side are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_meta  <= 1'b0;
            ot_sync  <= 1'b0;
            hpd_meta <= 1'b0;
            hpd_sync <= 1'b0;
        end else begin
            ot_meta  <= die_over_temp;
            ot_sync  <= ot_meta;
            hpd_meta <= hw_power_down;
            hpd_sync <= hpd_meta;
        end
    end

    // hardware and software power-down are simply or-ed
    assign powered_down = soft_pd | hpd_sync | thermal_tripped;
    assign amps_enabled = ~powered_down;

    always_comb begin
        do_ctrl_wr = 1'b0;
        do_ctrl_rd = 1'b0;
        do_mon     = 1'b0;
        do_pd      = 1'b0;
        do_pu      = 1'b0;
        do_rst     = 1'b0;
        if (take && sfr) begin
            case (link.function_address)
                `DCM_FN_CTRL: begin
                    do_ctrl_wr = ~link.read_not_write & ~powered_down;
                    do_ctrl_rd = link.read_not_write;
                end
                `DCM_FN_MONITOR:  do_mon = ~link.read_not_write & ~powered_down;
                `DCM_FN_SOFT_PD:  do_pd  = ~link.read_not_write;
                `DCM_FN_SOFT_PU:  do_pu  = ~link.read_not_write;
                // reset is not a register write, so power-down does not block it
                `DCM_FN_SOFT_RST: do_rst = ~link.read_not_write;
                default: ;
            endcase
        end
    end

    // control register; bit 5 is stored so readback is exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_control <= cr_reset;
        end else if (do_rst) begin
            device_control <= cr_reset;
        end else if (do_ctrl_wr) begin
            device_control <= link.cmd_data;
        end
    end

    assign pd_output_state  = device_control[`DCM_CR_PD_STATE];
    assign ref_level_sel    = device_control[`DCM_CR_REF_LEVEL];
    assign amp_boost        = device_control[`DCM_CR_BOOST];
    assign internal_ref_en  = device_control[`DCM_CR_INT_REF];
    assign monitor_en       = device_control[`DCM_CR_MON_EN];
    assign thermal_guard_en = device_control[`DCM_CR_THERM_EN];
    assign toggle_group_en  = device_control[`DCM_CR_TOG_HI:`DCM_CR_TOG_LO];

    // readback answer one cycle after the command is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.rsp_valid <= 1'b0;
            link.rsp_data  <= 12'h000;
        end else begin
            link.rsp_valid <= do_ctrl_rd;
            if (do_ctrl_rd) begin
                link.rsp_data <= device_control;
            end
        end
    end

    // soft power-down state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_pd <= 1'b0;
        end else if (do_rst || do_pu) begin
            soft_pd <= 1'b0;
        end else if (do_pd) begin
            soft_pd <= 1'b1;
        end
    end

    // trip is sticky; a hot die wins over a power-up in the same cycle
    assign trip_set = thermal_guard_en & ot_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thermal_tripped <= 1'b0;
        end else if (trip_set) begin
            thermal_tripped <= 1'b1;
        end else if ((do_pu || do_rst) && !ot_sync) begin
            thermal_tripped <= 1'b0;
        end
    end

    // monitor multiplexer select; starts at the float address 63 until a channel is chosen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_channel_addr <= `DCM_MON_HIZ;
        end else if (do_rst) begin
            monitor_channel_addr <= `DCM_MON_HIZ;
        end else if (do_mon) begin
            monitor_channel_addr <= link.cmd_data[`DCM_MON_ADDR_HI:`DCM_MON_ADDR_LO];
        end
    end

    // a select written before the enable is kept and used once enabled
    assign monitor_pin_hiz = monitor_en & (monitor_channel_addr == `DCM_MON_HIZ);
    assign monitor_routed  = monitor_en & ~monitor_pin_hiz;

    // per-channel A/B selection driven by the load pulse
    genvar ch;
    generate
        for (ch = 0; ch < `DCM_NUM_CH; ch++) begin : g_toggle
            localparam int grp = ch >> `DCM_GROUP_SHIFT;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    toggle_use_b[ch] <= 1'b0;
                end else if (do_rst || !toggle_group_en[grp]) begin
                    toggle_use_b[ch] <= 1'b0;
                end else if (link.load_outputs) begin
                    toggle_use_b[ch] <= ~toggle_use_b[ch];
                end
            end
        end
    endgenerate

endmodule // dcm_device

// File: hw/dcm_host.sv
`include "dcm_params.svh"

module dcm_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    dcm_link_if.host         link
);
    import dcm_pkg::*;

    dcm_host_state_t state;
    dcm_word_t       rdata;
    logic            rdata_valid;
    logic            refused;
    logic            mon_en_shadow;
    logic            access;
    logic            wr_cmd;
    logic            busy;
    logic            mapped;
    logic            is_mon;
    logic            taken;

    assign busy   = (state != DCM_IDLE);
    assign access = psel & penable;
    assign mapped = (paddr == `DCM_APB_CMD) || (paddr == `DCM_APB_STATUS)
                 || (paddr == `DCM_APB_RDATA) || (paddr == `DCM_APB_LOAD);
    // a new command stalls the bus until the previous one finished
    assign pready = ~(access & pwrite & (paddr == `DCM_APB_CMD) & busy);
    assign pslverr = access & ~mapped;
    assign wr_cmd = access & pready & pwrite & (paddr == `DCM_APB_CMD);
    assign is_mon = (pwdata[`DCM_CMD_RS_HI:`DCM_CMD_RS_LO] == `DCM_RS_SFR)
                 && (pwdata[`DCM_CMD_FN_HI:`DCM_CMD_FN_LO] == `DCM_FN_MONITOR);
    assign taken  = link.cmd_valid & link.cmd_ready;

    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                `DCM_APB_STATUS: begin
                    prdata[`DCM_ST_BUSY]        = busy;
                    prdata[`DCM_ST_RDATA_VALID] = rdata_valid;
                    prdata[`DCM_ST_REFUSED]     = refused;
                end
                `DCM_APB_RDATA: prdata[11:0] = rdata;
                default: ;
            endcase
        end
    end

    // command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DCM_IDLE;
        end else begin
            case (state)
                DCM_IDLE: begin
                    if (wr_cmd && !(is_mon && !mon_en_shadow)) begin
                        state <= DCM_ISSUE;
                    end
                end
                DCM_ISSUE: begin
                    // only a control readback is answered; waiting on any other read would hang
                    if (taken && link.read_not_write && !link.reg_select_hi
                        && !link.reg_select_lo && link.function_address == `DCM_FN_CTRL) begin
                        state <= DCM_WAIT_RSP;
                    end else if (taken) begin
                        state <= DCM_IDLE;
                    end
                end
                DCM_WAIT_RSP: begin
                    if (link.rsp_valid) begin
                        state <= DCM_IDLE;
                    end
                end
                default: state <= DCM_IDLE;
            endcase
        end
    end

    assign link.cmd_valid = (state == DCM_ISSUE);

    // command fields held steady from the APB write until taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.reg_select_hi    <= 1'b0;
            link.reg_select_lo    <= 1'b0;
            link.function_address <= `DCM_FN_NOP;
            link.read_not_write   <= 1'b0;
            link.cmd_data         <= 12'h000;
        end else if (wr_cmd) begin
            link.reg_select_hi    <= pwdata[`DCM_CMD_RS_HI];
            link.reg_select_lo    <= pwdata[`DCM_CMD_RS_LO];
            link.function_address <= pwdata[`DCM_CMD_FN_HI:`DCM_CMD_FN_LO];
            link.read_not_write   <= pwdata[`DCM_CMD_READ];
            link.cmd_data         <= pwdata[`DCM_CMD_DATA_HI:`DCM_CMD_DATA_LO];
        end
    end

    // shadow of the monitor enable last written to the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_en_shadow <= 1'b0;
        end else if (taken && !link.reg_select_hi && !link.reg_select_lo) begin
            if (link.function_address == `DCM_FN_CTRL && !link.read_not_write) begin
                mon_en_shadow <= link.cmd_data[`DCM_CR_MON_EN];
            end else if (link.function_address == `DCM_FN_SOFT_RST) begin
                mon_en_shadow <= 1'b0;
            end
        end
    end

    // monitor select without enable is refused, never sent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (wr_cmd && is_mon && !mon_en_shadow) begin
            refused <= 1'b1;
        end else if (access && pwrite && paddr == `DCM_APB_STATUS
                     && pwdata[`DCM_ST_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // readback capture; new data wins over a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata       <= 12'h000;
            rdata_valid <= 1'b0;
        end else if (link.rsp_valid && state == DCM_WAIT_RSP) begin
            rdata       <= link.rsp_data;
            rdata_valid <= 1'b1;
        end else if (access && !pwrite && paddr == `DCM_APB_RDATA) begin
            rdata_valid <= 1'b0;
        end
    end

    // load pulse, one cycle per write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.load_outputs <= 1'b0;
        end else begin
            link.load_outputs <= access & pwrite & (paddr == `DCM_APB_LOAD);
        end
    end

endmodule // dcm_host

// File: hw/dcm_link_if.sv
interface dcm_link_if;
    import dcm_pkg::*;
    logic      cmd_valid;
    logic      cmd_ready;
    logic      reg_select_hi;
    logic      reg_select_lo;
    dcm_fn_t   function_address;
    logic      read_not_write;
    dcm_word_t cmd_data;
    logic      rsp_valid;
    dcm_word_t rsp_data;
    logic      load_outputs;

    modport device (
        input  cmd_valid,
        output cmd_ready,
        input  reg_select_hi,
        input  reg_select_lo,
        input  function_address,
        input  read_not_write,
        input  cmd_data,
        output rsp_valid,
        output rsp_data,
        input  load_outputs
    );
    modport host (
        output cmd_valid,
        input  cmd_ready,
        output reg_select_hi,
        output reg_select_lo,
        output function_address,
        output read_not_write,
        output cmd_data,
        input  rsp_valid,
        input  rsp_data,
        output load_outputs
    );
endinterface

// File: hw/dcm_params.svh
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH

// link command fields
`define DCM_RS_SFR          2'b00
`define DCM_FN_NOP          6'h00
`define DCM_FN_SOFT_PD      6'h08
`define DCM_FN_SOFT_PU      6'h09
`define DCM_FN_MONITOR      6'h0a
`define DCM_FN_CTRL         6'h0c
`define DCM_FN_SOFT_RST     6'h0f

// device control register layout
`define DCM_CR_PD_STATE     11
`define DCM_CR_REF_LEVEL    10
`define DCM_CR_BOOST        9
`define DCM_CR_INT_REF      8
`define DCM_CR_MON_EN       7
`define DCM_CR_THERM_EN     6
`define DCM_CR_TOG_HI       4
`define DCM_CR_TOG_LO       0
`define DCM_CR_RESET        12'h800
`define DCM_CR_REF_MASK     12'h400

// monitor select
`define DCM_MON_ADDR_HI     11
`define DCM_MON_ADDR_LO     6
`define DCM_MON_HIZ         6'h3f

// channels and toggle groups
`define DCM_NUM_CH          40
`define DCM_GROUP_SHIFT     3
`define DCM_NUM_GROUPS      5

// host APB register map
`define DCM_APB_CMD         12'h000
`define DCM_APB_STATUS      12'h004
`define DCM_APB_RDATA       12'h008
`define DCM_APB_LOAD        12'h00c
`define DCM_CMD_DATA_HI     11
`define DCM_CMD_DATA_LO     0
`define DCM_CMD_FN_HI       17
`define DCM_CMD_FN_LO       12
`define DCM_CMD_READ        18
`define DCM_CMD_RS_LO       19
`define DCM_CMD_RS_HI       20
`define DCM_ST_BUSY         0
`define DCM_ST_RDATA_VALID  1
`define DCM_ST_REFUSED      2

`endif

// File: hw/dcm_pkg.sv
package dcm_pkg;
    typedef logic [11:0] dcm_word_t;
    typedef logic [5:0]  dcm_fn_t;
    typedef logic [1:0]  dcm_rs_t;
    typedef enum logic [1:0] {
        DCM_IDLE,
        DCM_ISSUE,
        DCM_WAIT_RSP
    } dcm_host_state_t;
endpackage
